// ==== design/mac_unit_pkg.sv ====
/*
 * package for the snooping multiply-accumulate unit: mode codes, bit positions,
 * widths and the structs that carry the bus access and result words.
 * assumes nothing of its surroundings.
 */
package mac_unit_pkg;

	localparam int unsigned WORD_W = 16;
	localparam int unsigned ACC_W = 42;
	localparam int unsigned SAT_W = 32;
	localparam int unsigned EXT_W = 10;

	// mode field codes, control bits 2..0 (sign for products / wide for accumulates, product, accumulate)
	localparam logic [2:0] MODE_SAT_MAC = 3'h1;
	localparam logic [2:0] MODE_WIDE_MAC = 3'h5;
	localparam logic [2:0] MODE_UMUL = 3'h2;
	localparam logic [2:0] MODE_SMUL = 3'h6;

	localparam int unsigned SNOOP_EN_BIT = 6;
	localparam int unsigned WIPE_BIT = 7;
	localparam int unsigned OVF_BIT = 0;

	// byte step between the three held multiplier words
	localparam logic [15:0] STEP_B = 16'h0002;
	localparam logic [15:0] STEP_C = 16'h0004;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	typedef enum logic [1:0] {
		SEL_NONE = 2'h0,
		SEL_A = 2'h1,
		SEL_B = 2'h3,
		SEL_C = 2'h2
	} held_sel_e;

	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		logic [15:0] data;
	} bus_access_s;

	typedef struct packed {
		logic [15:0] ext;
		logic [15:0] high;
		logic [15:0] low;
	} result_words_s;

	// which held word an address selects, relative to a base
	function automatic held_sel_e held_select(input logic [15:0] addr, input logic [15:0] base);
		if (addr == base) begin
			return SEL_A;
		end else if (addr == 16'(base + STEP_B)) begin
			return SEL_B;
		end else if (addr == 16'(base + STEP_C)) begin
			return SEL_C;
		end else begin
			return SEL_NONE;
		end
	endfunction : held_select

endpackage : mac_unit_pkg

// ==== design/mac_arith.sv ====
/*
 * combinational multiply and accumulate core.
 * assumes the caller registers the result words and supplies the mode code.
 */
`timescale 1ns/10ps
module mac_arith (
	input wire logic [2:0] mode,
	input wire logic [15:0] multiplier,
	input wire logic [15:0] multiplicand,
	input wire logic [41:0] acc_in,
	output logic [41:0] acc_out,
	output logic overflow
);
	logic is_signed;
	logic [31:0] prod32;
	logic signed [41:0] prod_ext;
	logic signed [41:0] sum42;
	logic signed [32:0] sum33;
	logic [31:0] acc_lo;

	always_comb begin
		is_signed = mode[2] || (mode == mac_unit_pkg::MODE_SAT_MAC);
		if (is_signed) begin
			prod32 = 32'($signed(multiplier) * $signed(multiplicand));
			prod_ext = {{10{prod32[31]}}, prod32};
		end else begin
			prod32 = 32'(multiplier * multiplicand);
			prod_ext = {10'h000, prod32};
		end
		acc_lo = acc_in[31:0];
		sum42 = 42'($signed(acc_in) + prod_ext);
		sum33 = 33'($signed({acc_lo[31], acc_lo}) + $signed({prod32[31], prod32}));
		overflow = 1'b0;
		case (mode)
			mac_unit_pkg::MODE_SAT_MAC: begin
				// saturating: 32-bit accumulate with clamp
				overflow = sum33[32] != sum33[31];
				if (overflow) begin
					acc_out = sum33[32] ? {10'h000, 32'h8000_0000} : {10'h000, 32'h7FFF_FFFF};
				end else begin
					acc_out = {10'h000, sum33[31:0]};
				end
			end
			mac_unit_pkg::MODE_WIDE_MAC: begin
				acc_out = sum42;
			end
			mac_unit_pkg::MODE_UMUL, mac_unit_pkg::MODE_SMUL: begin
				acc_out = prod_ext;
			end
			default: begin
				acc_out = acc_in;
			end
		endcase
	end
endmodule : mac_arith

// ==== design/snoop_mac.sv ====
/*
 * snooping 16x16 multiply / multiply-accumulate unit, top level.
 * assumes a synchronous cpu bus on mclk with one-cycle access strobes and
 * unit register writes presented as plain strobed ports.
 */
`timescale 1ns/10ps
module snoop_mac (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] ctrl_wdata,
	input wire logic ctrl_we,
	input wire logic [7:0] base_wdata,
	input wire logic base_we,
	input wire logic [7:0] mplr_off_wdata,
	input wire logic mplr_off_we,
	input wire logic [7:0] mcand_off_wdata,
	input wire logic mcand_off_we,
	input wire logic [15:0] direct_wdata,
	input wire logic direct_multiplier_we,
	input wire logic direct_multiplicand_we,
	input wire logic [15:0] result_wdata,
	input wire logic result_ext_we,
	input wire logic result_high_we,
	input wire logic result_low_we,
	input wire mac_unit_pkg::bus_access_s cpu_bus,
	output logic [7:0] unit_control_reg,
	output logic [15:0] held_multiplier_a,
	output logic [15:0] held_multiplier_b,
	output logic [15:0] held_multiplier_c,
	output logic [15:0] direct_multiplier_reg,
	output mac_unit_pkg::result_words_s result_words,
	output logic op_done
);
	// ****************************************
	// register state
	// ****************************************
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] base_reg, base_next;
	logic [7:0] mplr_off_reg, mplr_off_next;
	logic [7:0] mcand_off_reg, mcand_off_next;
	logic [15:0] held_a_reg, held_a_next;
	logic [15:0] held_b_reg, held_b_next;
	logic [15:0] held_c_reg, held_c_next;
	logic [15:0] mr_reg, mr_next;
	logic [15:0] last_mplr_reg, last_mplr_next;
	logic [15:0] ext_reg, ext_next;
	logic [15:0] high_reg, high_next;
	logic [15:0] low_reg, low_next;
	logic done_reg, done_next;

	logic snoop_on;
	logic [15:0] mplr_base;
	logic [15:0] mcand_base;
	mac_unit_pkg::held_sel_e mplr_hit;
	mac_unit_pkg::held_sel_e mcand_hit;
	logic start;
	logic [15:0] op_multiplier;
	logic [15:0] op_multiplicand;
	logic [41:0] acc_in;
	logic [41:0] acc_out;
	logic acc_ovf;
	logic wide_mode;

	mac_arith u_arith (
		.mode(ctrl_reg[2:0]),
		.multiplier(op_multiplier),
		.multiplicand(op_multiplicand),
		.acc_in(acc_in),
		.acc_out(acc_out),
		.overflow(acc_ovf)
	);

	// ****************************************
	// snoop decode and operand selection
	// ****************************************
	always_comb begin
		snoop_on = ctrl_reg[mac_unit_pkg::SNOOP_EN_BIT];
		mplr_base = {base_reg, mplr_off_reg};
		mcand_base = {base_reg, mcand_off_reg};
		mplr_hit = mac_unit_pkg::SEL_NONE;
		mcand_hit = mac_unit_pkg::SEL_NONE;
		if (snoop_on && cpu_bus.valid) begin
			mplr_hit = mac_unit_pkg::held_select(cpu_bus.addr, mplr_base);
			mcand_hit = mac_unit_pkg::held_select(cpu_bus.addr, mcand_base);
		end
		// a direct multiplicand takes the latest multiplier, direct or snooped
		op_multiplier = last_mplr_reg;
		op_multiplicand = direct_wdata;
		start = direct_multiplicand_we;
		if (mcand_hit != mac_unit_pkg::SEL_NONE) begin
			start = 1'b1;
			op_multiplicand = cpu_bus.data;
			case (mcand_hit)
				mac_unit_pkg::SEL_A: op_multiplier = held_a_reg;
				mac_unit_pkg::SEL_B: op_multiplier = held_b_reg;
				mac_unit_pkg::SEL_C: op_multiplier = held_c_reg;
				default: op_multiplier = mr_reg;
			endcase
		end else if (direct_multiplicand_we && mplr_hit != mac_unit_pkg::SEL_NONE) begin
			op_multiplier = cpu_bus.data;
		end
		wide_mode = ctrl_reg[2:0] != mac_unit_pkg::MODE_SAT_MAC;
		acc_in = wide_mode ? {ext_reg[9:0], high_reg, low_reg}
			: {10'h000, high_reg, low_reg};
	end

	// ****************************************
	// next-state for registers
	// ****************************************
	always_comb begin
		ctrl_next = ctrl_we ? ctrl_wdata : ctrl_reg;
		base_next = base_we ? base_wdata : base_reg;
		mplr_off_next = mplr_off_we ? mplr_off_wdata : mplr_off_reg;
		mcand_off_next = mcand_off_we ? mcand_off_wdata : mcand_off_reg;
		mr_next = direct_multiplier_we ? direct_wdata : mr_reg;
		if (direct_multiplier_we) begin
			last_mplr_next = direct_wdata;
		end else if (mplr_hit != mac_unit_pkg::SEL_NONE) begin
			last_mplr_next = cpu_bus.data;
		end else begin
			last_mplr_next = last_mplr_reg;
		end
		// held words change only on their own snoop hit
		held_a_next = held_a_reg;
		held_b_next = held_b_reg;
		held_c_next = held_c_reg;
		case (mplr_hit)
			mac_unit_pkg::SEL_A: held_a_next = cpu_bus.data;
			mac_unit_pkg::SEL_B: held_b_next = cpu_bus.data;
			mac_unit_pkg::SEL_C: held_c_next = cpu_bus.data;
			default: ;
		endcase
		ext_next = ext_reg;
		high_next = high_reg;
		low_next = low_reg;
		done_next = start;
		if ((result_ext_we || result_high_we || result_low_we)
			&& ctrl_reg[mac_unit_pkg::WIPE_BIT]) begin
			ext_next = mac_unit_pkg::WORD_RESET;
			high_next = mac_unit_pkg::WORD_RESET;
			low_next = mac_unit_pkg::WORD_RESET;
		end else if (result_ext_we || result_high_we || result_low_we) begin
			if (result_ext_we) ext_next = result_wdata;
			if (result_high_we) high_next = result_wdata;
			if (result_low_we) low_next = result_wdata;
		end else if (start) begin
			high_next = acc_out[31:16];
			low_next = acc_out[15:0];
			if (ctrl_reg[2:0] == mac_unit_pkg::MODE_SAT_MAC) begin
				// sticky overflow flag; a result word write in the same cycle wins
				ext_next = {ext_reg[15:1], ext_reg[mac_unit_pkg::OVF_BIT] | acc_ovf};
			end else if (ctrl_reg[2:0] == mac_unit_pkg::MODE_WIDE_MAC
				|| ctrl_reg[2:0] == mac_unit_pkg::MODE_UMUL
				|| ctrl_reg[2:0] == mac_unit_pkg::MODE_SMUL) begin
				ext_next = {{6{acc_out[41]}}, acc_out[41:32]};
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= mac_unit_pkg::CTRL_RESET;
			base_reg <= mac_unit_pkg::BYTE_RESET;
			mplr_off_reg <= mac_unit_pkg::BYTE_RESET;
			mcand_off_reg <= mac_unit_pkg::BYTE_RESET;
			held_a_reg <= mac_unit_pkg::WORD_RESET;
			held_b_reg <= mac_unit_pkg::WORD_RESET;
			held_c_reg <= mac_unit_pkg::WORD_RESET;
			mr_reg <= mac_unit_pkg::WORD_RESET;
			last_mplr_reg <= mac_unit_pkg::WORD_RESET;
			ext_reg <= mac_unit_pkg::WORD_RESET;
			high_reg <= mac_unit_pkg::WORD_RESET;
			low_reg <= mac_unit_pkg::WORD_RESET;
			done_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			base_reg <= base_next;
			mplr_off_reg <= mplr_off_next;
			mcand_off_reg <= mcand_off_next;
			held_a_reg <= held_a_next;
			held_b_reg <= held_b_next;
			held_c_reg <= held_c_next;
			mr_reg <= mr_next;
			last_mplr_reg <= last_mplr_next;
			ext_reg <= ext_next;
			high_reg <= high_next;
			low_reg <= low_next;
			done_reg <= done_next;
		end
	end

	assign unit_control_reg = ctrl_reg;
	assign held_multiplier_a = held_a_reg;
	assign held_multiplier_b = held_b_reg;
	assign held_multiplier_c = held_c_reg;
	assign direct_multiplier_reg = mr_reg;
	assign result_words = '{ext: ext_reg, high: high_reg, low: low_reg};
	assign op_done = done_reg;

	// ****************************************
	// assertions
	// ****************************************
	logic no_rw;
	assign no_rw = !(result_ext_we || result_high_we || result_low_we);

	a_snoop_gate_off: assert property (@(posedge mclk) disable iff (!rst_n)
		!ctrl_reg[6] && !ctrl_we |=> $stable(held_a_reg) && $stable(held_b_reg)
		&& $stable(held_c_reg)) else $error("held word changed with snooping off");
	a_held_a_load: assert property (@(posedge mclk) disable iff (!rst_n)
		ctrl_reg[6] && cpu_bus.valid && cpu_bus.addr == {base_reg, mplr_off_reg}
		|=> held_a_reg == $past(cpu_bus.data)) else $error("held a not loaded");
	a_held_c_load: assert property (@(posedge mclk) disable iff (!rst_n)
		ctrl_reg[6] && cpu_bus.valid
		&& cpu_bus.addr == 16'({base_reg, mplr_off_reg} + 16'h0004)
		|=> held_c_reg == $past(cpu_bus.data)) else $error("held c not loaded");
	a_held_b_keep: assert property (@(posedge mclk) disable iff (!rst_n)
		mplr_hit != mac_unit_pkg::SEL_B |=> $stable(held_b_reg))
		else $error("held b changed without hit");
	a_start_done: assert property (@(posedge mclk) disable iff (!rst_n)
		direct_multiplicand_we |=> op_done) else $error("no start on load");
	a_mcand_snoop: assert property (@(posedge mclk) disable iff (!rst_n)
		mcand_hit == mac_unit_pkg::SEL_A && no_rw && ctrl_reg[2:0] == 3'h2
		|=> {high_reg, low_reg} == 32'($past(held_a_reg) * $past(cpu_bus.data)))
		else $error("snooped multiplicand product wrong");
	a_wipe_all: assert property (@(posedge mclk) disable iff (!rst_n)
		ctrl_reg[7] && !no_rw |=> ext_reg == 16'h0000 && high_reg == 16'h0000
		&& low_reg == 16'h0000) else $error("wipe missed");
	a_wide_accum: assert property (@(posedge mclk) disable iff (!rst_n)
		start && no_rw && ctrl_reg[2:0] == 3'h5 |=> {ext_reg[9:0], high_reg, low_reg}
		== 42'($past({ext_reg[9:0], high_reg, low_reg})
		+ 42'($signed($past(op_multiplier)) * $signed($past(op_multiplicand)))))
		else $error("wide accumulate wrong");
	a_sat_flag: assert property (@(posedge mclk) disable iff (!rst_n)
		start && no_rw && ctrl_reg[2:0] == 3'h1 && acc_ovf
		|=> ext_reg[0] && {high_reg, low_reg}
		== ($past(high_reg[15]) ? 32'h8000_0000 : 32'h7fff_ffff))
		else $error("saturation flag or clamp wrong");
	a_smul_prod: assert property (@(posedge mclk) disable iff (!rst_n)
		direct_multiplicand_we && no_rw && mcand_hit == mac_unit_pkg::SEL_NONE
		&& mplr_hit == mac_unit_pkg::SEL_NONE
		&& ctrl_reg[2:0] == 3'h6 |=> $signed({high_reg, low_reg})
		== 32'($signed($past(last_mplr_reg)) * $signed($past(direct_wdata))))
		else $error("signed product wrong");

	c_snoop_mult: cover property (@(posedge mclk) disable iff (!rst_n)
		mplr_hit != mac_unit_pkg::SEL_NONE ##[1:8] mcand_hit != mac_unit_pkg::SEL_NONE);
	c_sat_ovf: cover property (@(posedge mclk) disable iff (!rst_n)
		start && acc_ovf);
	c_wipe: cover property (@(posedge mclk) disable iff (!rst_n)
		ctrl_reg[7] && result_ext_we);
	c_direct: cover property (@(posedge mclk) disable iff (!rst_n)
		direct_multiplier_we ##1 direct_multiplicand_we);
endmodule : snoop_mac

// ==== verification/cpu_bus_model.sv ====
/*
 * model of the snooped cpu bus: one word access per call.
 * assumes each call starts at a falling mclk edge.
 */
`timescale 1ns/10ps
module cpu_bus_model (
	input wire logic mclk,
	output mac_unit_pkg::bus_access_s bus
);
	initial begin
		bus = '0;
	end

	// whole word for one cycle, then lines scrambled so stale values never match
	task automatic access(input logic [15:0] addr, input logic [15:0] data);
		bus = {1'b1, addr, data};
		@(negedge mclk);
		bus = {1'b0, ~addr, ~data};
	endtask : access
endmodule : cpu_bus_model

// ==== verification/tb_snooping_multiply_accumulate.sv ====
/*
 * self-checking bench for the snooping multiply-accumulate unit.
 * assumes the bus model beside it and the design's one-cycle answer.
 */
`timescale 1ns/10ps
module tb_snooping_multiply_accumulate;
	logic mclk, rst_n, ctrl_we, base_we, mplr_off_we, mcand_off_we, op_done;
	logic direct_multiplier_we, direct_multiplicand_we;
	logic result_ext_we, result_high_we, result_low_we;
	logic [7:0] ctrl_wdata, base_wdata, mplr_off_wdata, mcand_off_wdata, unit_control_reg;
	logic [15:0] direct_wdata, result_wdata, direct_multiplier_reg;
	logic [15:0] held_multiplier_a, held_multiplier_b, held_multiplier_c;
	mac_unit_pkg::bus_access_s cpu_bus;
	mac_unit_pkg::result_words_s result_words;
	int err_count, total_checks;

	snoop_mac i_snoop_mac (.mclk, .rst_n, .ctrl_wdata, .ctrl_we, .base_wdata, .base_we,
		.mplr_off_wdata, .mplr_off_we, .mcand_off_wdata, .mcand_off_we, .direct_wdata,
		.direct_multiplier_we, .direct_multiplicand_we, .result_wdata, .result_ext_we,
		.result_high_we, .result_low_we, .cpu_bus, .unit_control_reg, .held_multiplier_a,
		.held_multiplier_b, .held_multiplier_c, .direct_multiplier_reg, .result_words, .op_done);

	cpu_bus_model i_cpu_bus_model (.mclk, .bus(cpu_bus));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results

	task automatic wait_done;
		int n;
		n = 0;
		while (op_done !== 1'b1) begin
			@(posedge mclk);
			#1;
			n++;
			if (n > 4) begin
				err_count++;
				$display("MISMATCH op_done expected 1 seen 0");
				results();
			end
		end
		@(negedge mclk);
	endtask : wait_done

	task automatic setc(input logic [7:0] v);
		ctrl_wdata = v;
		ctrl_we = 1'b1;
		@(negedge mclk);
		ctrl_we = 1'b0;
	endtask : setc

	task automatic setw(input int i, input logic v);
		case (i)
			0: result_ext_we = v;
			1: result_high_we = v;
			default: result_low_we = v;
		endcase
	endtask : setw

	task automatic wword(input int i, input logic [15:0] d);
		result_wdata = d;
		setw(i, 1'b1);
		@(negedge mclk);
		setw(i, 1'b0);
	endtask : wword

	task automatic wres(input logic [47:0] r);
		wword(0, r[47:32]);
		wword(1, r[31:16]);
		wword(2, r[15:0]);
	endtask : wres

	task automatic mcand_go(input logic [15:0] b);
		direct_wdata = b;
		direct_multiplicand_we = 1'b1;
		@(negedge mclk);
		direct_multiplicand_we = 1'b0;
		wait_done();
	endtask : mcand_go

	// multiplicand written in the cycle right after the multiplier
	task automatic direct_op(input logic [15:0] a, input logic [15:0] b);
		direct_wdata = a;
		direct_multiplier_we = 1'b1;
		@(negedge mclk);
		direct_multiplier_we = 1'b0;
		mcand_go(b);
	endtask : direct_op

	function automatic logic [47:0] exp_res(input logic [2:0] m, input logic [15:0] a,
		input logic [15:0] b, input logic [47:0] r);
		logic [47:0] p, w;
		logic [32:0] s;
		if (m == mac_unit_pkg::MODE_UMUL) begin
			p = {32'h0000_0000, a} * {32'h0000_0000, b};
		end else begin
			p = {{32{a[15]}}, a} * {{32{b[15]}}, b};
		end
		if (m == mac_unit_pkg::MODE_SAT_MAC) begin
			s = {r[31], r[31:0]} + p[32:0];
			if (s[32] != s[31]) begin
				return {r[47:33], 1'b1, s[32] ? 32'h8000_0000 : 32'h7fff_ffff};
			end
			return {r[47:32], s[31:0]};
		end
		w = (m == mac_unit_pkg::MODE_WIDE_MAC) ? r + p : p;
		return {{6{w[41]}}, w[41:0]};
	endfunction : exp_res

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		logic [2:0] modes [4];
		logic [47:0] r;
		logic [15:0] a, b, m, maddr, caddr;
		logic [15:0] d [3];
		logic [7:0] base;
		err_count = 0;
		total_checks = 0;
		rst_n = 1'b0;
		{ctrl_we, base_we, mplr_off_we, mcand_off_we, direct_multiplier_we} = '0;
		{direct_multiplicand_we, result_ext_we, result_high_we, result_low_we} = '0;
		{ctrl_wdata, base_wdata, mplr_off_wdata, mcand_off_wdata, direct_wdata, result_wdata} = '0;
		modes = '{mac_unit_pkg::MODE_UMUL, mac_unit_pkg::MODE_SMUL,
			mac_unit_pkg::MODE_WIDE_MAC, mac_unit_pkg::MODE_SAT_MAC};
		void'($urandom(32'h4b72));
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		rst_n = 1'b1;
		chk("reset result", 48'h0000_0000_0000, result_words);
		// every mode, saturation corners in the first passes
		for (int i = 0; i < 16; i++) begin
			a = 16'($urandom);
			b = 16'($urandom);
			r = 48'({$urandom, $urandom});
			r[47:42] = {6{r[41]}};
			if (modes[i % 4] == mac_unit_pkg::MODE_SAT_MAC && i < 8) begin
				r[31:0] = i[2] ? 32'h8000_0005 : 32'h7fff_fff0;
				a = i[2] ? 16'h8000 : 16'h4000;
				b = 16'h4000;
			end
			setc({5'h00, modes[i % 4]});
			wres(r);
			direct_op(a, b);
			chk("direct multiplier", 48'(a), 48'(direct_multiplier_reg));
			chk("mac", exp_res(modes[i % 4], a, b, r), result_words);
		end
		for (int k = 0; k < 3; k++) begin
			r = 48'({$urandom, $urandom});
			setc(8'h00);
			wres(r);
			chk("result write", r, result_words);
			setc(8'h80);
			chk("control", 48'h0000_0000_0080, 48'(unit_control_reg));
			wword(k, 16'($urandom) | 16'h0001);
			chk("wipe", 48'h0000_0000_0000, result_words);
		end
		// multiplier words straddle a base boundary
		base = 8'($urandom);
		maddr = {base, 8'hfc};
		caddr = {base, 8'h10};
		setc(8'h42);
		base_wdata = base;
		mplr_off_wdata = 8'hfc;
		mcand_off_wdata = 8'h10;
		{base_we, mplr_off_we, mcand_off_we} = 3'h7;
		@(negedge mclk);
		{base_we, mplr_off_we, mcand_off_we} = 3'h0;
		for (int k = 0; k < 3; k++) begin
			d[k] = 16'($urandom);
			i_cpu_bus_model.access(maddr + 16'(2 * k), d[k]);
			@(negedge mclk);
		end
		i_cpu_bus_model.access(maddr + 16'h0006, ~d[2]);
		@(negedge mclk);
		chk("held a", 48'(d[0]), 48'(held_multiplier_a));
		chk("held b", 48'(d[1]), 48'(held_multiplier_b));
		chk("held c", 48'(d[2]), 48'(held_multiplier_c));
		for (int k = 0; k < 3; k++) begin
			m = 16'($urandom);
			i_cpu_bus_model.access(caddr + 16'(2 * k), m);
			wait_done();
			chk("snoop", exp_res(modes[0], d[k], m, 48'h0000_0000_0000), result_words);
		end
		setc(8'h02);
		i_cpu_bus_model.access(maddr, ~d[0]);
		@(negedge mclk);
		chk("snoop off", 48'(d[0]), 48'(held_multiplier_a));
		setc(8'h45);
		wres(48'h0000_0000_0000);
		// differs from the direct multiplier still held
		a = ~a;
		i_cpu_bus_model.access(maddr + 16'h0002, a);
		mcand_go(b);
		chk("snoop direct", exp_res(modes[2], a, b, 48'h0000_0000_0000), result_words);
		// reset again in mid-run
		rst_n = 1'b0;
		@(negedge mclk);
		rst_n = 1'b1;
		chk("reset again", 48'h0000_0000_0000, result_words);
		chk("reset regs", 48'h0000_0000_0000,
			48'({held_multiplier_b, direct_multiplier_reg, unit_control_reg, op_done}));
		results();
	end
endmodule : tb_snooping_multiply_accumulate
